// File: logic/sfa_cfg.svh
// Constants of the subtract-family datapath.
`ifndef SFA_CFG_SVH
`define SFA_CFG_SVH
`define SFA_XLEN 64
`define SFA_IMM_W 16
`define SFA_ALL_ONES 64'hffff_ffff_ffff_ffff
`define SFA_TOP_64 0
`define SFA_TOP_32 32
// Bus register offsets and interrupt bit positions.
`define SFA_OFF_STATUS 32'h0000_0000
`define SFA_OFF_ENABLE 32'h0000_0004
`define SFA_OFF_CLEAR 32'h0000_0008
`define SFA_OFF_FLAGS 32'h0000_000c
`define SFA_OFF_CTRL 32'h0000_0010
`define SFA_IRQ_DONE 0
`define SFA_IRQ_WRAP 1
`define SFA_IRQ_W 2
`endif

// File: logic/sfa_pkg.sv
// Types of the subtract-family datapath.
package sfa_pkg;
    typedef enum logic [2:0]
    {
        SFA_OP_PLAIN,
        SFA_OP_CARRY,
        SFA_OP_EXT,
        SFA_OP_IMM,
        SFA_OP_MINUS1,
        SFA_OP_ZERO
    } sfa_op_e;
    typedef enum logic [1:0]
    {
        SFA_BUS_IDLE,
        SFA_BUS_DATA
    } sfa_bus_e;
endpackage

// File: logic/sfa_add_if.sv
// Operand and sum bundle between the top and its adder.
interface sfa_add_if;
    logic [63:0] addend_a;
    logic [63:0] addend_b;
    logic carry_in;
    logic [63:0] sum;
    logic [64:0] carries;
    modport top (output addend_a, addend_b, carry_in, input sum, carries);
    modport adder (input addend_a, addend_b, carry_in, output sum, carries);
endinterface

// File: logic/sfa_adder.sv
// Ripple adder exposing every bit carry.
module sfa_adder
(
    sfa_add_if.adder add
);
    // Bit i carries out into carries[i+1]; carries[64] is the final carry.
    always_comb
    begin
        add.carries[0] = add.carry_in;
        for (int i = 0; i < 64; i++)
        begin
            add.sum[i] = add.addend_a[i] ^ add.addend_b[i] ^ add.carries[i];
            add.carries[i + 1] = (add.addend_a[i] & add.addend_b[i])
                | ((add.addend_a[i] ^ add.addend_b[i]) & add.carries[i]);
        end
    end
endmodule // sfa_adder

// File: logic/sfa_alu.sv
// Subtract-family datapath with flag registers and an AHB-Lite status port.
`include "sfa_cfg.svh"
// Summary of operation
// - Plain form: result is inverted first operand plus second operand plus one.
// - Carrying form: same sum, carry out captured.
// - Extended form: carry flag replaces the constant one.
// - Immediate form: sign-extend 16-bit immediate, add with inverted operand and one.
// - Immediate form updates carry only, never condition field or overflow.
// - Minus-one form: inverted operand plus carry plus all ones.
// - Zero form: inverted operand plus carry, carry captured, no second operand.
// - Carry flag from selected top bit for all but plain form.
// - Overflow enable: wrap flag is XOR of top two carries, ORed into sticky.
// - Record: condition field gets negative, positive, zero and sticky.
// - Four variants by overflow enable and record; each enables its own updates.
module sfa_alu
    import sfa_pkg::*;
(
    // Clock and reset.
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    // Issue port.
    input wire logic ISSUE_VALID_I,
    input wire sfa_op_e ISSUE_OP_I,
    input wire logic OVF_ENABLE_I,
    input wire logic RECORD_BIT_I,
    input wire logic MODE32_I,
    input wire logic [63:0] FIRST_OPERAND_I,
    input wire logic [63:0] SECOND_OPERAND_I,
    input wire logic [15:0] SIGNED_IMMEDIATE_I,
    // Result port.
    output logic RESULT_VALID_O,
    output logic [63:0] RESULT_O,
    output logic BORROW_OUT_BIT_O,
    output logic SIGNED_WRAP_FLAG_O,
    output logic STICKY_WRAP_O,
    output logic [3:0] CONDITION_FIELD_ZERO_O,
    // AHB-Lite slave.
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Interrupt.
    output logic IRQ_O
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed
    {
        // Issue result and architectural flags.
        logic valid;
        logic [63:0] result;
        logic ca;
        logic ov;
        logic so;
        logic [3:0] cr0;
        // Interrupt status and enable, and the sticky-clear pulse.
        logic [`SFA_IRQ_W-1:0] irq_status;
        logic [`SFA_IRQ_W-1:0] irq_enable;
        logic sticky_clr;
        // Bus data-phase context and the captured read word.
        sfa_bus_e bus_state;
        logic bus_write;
        logic [31:0] bus_addr;
        logic [31:0] rdata;
    } sfa_state_s;

    sfa_state_s st_reg;
    sfa_state_s st_next;
    sfa_add_if add ();

    // ------------------------------------------------------------------
    // Adder
    // ------------------------------------------------------------------
    sfa_adder u_adder
    (
        .add(add)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Maps the 32-bit mode flag to the LSB-first position of the top bit (31 or 63).
    function automatic logic [5:0] lsb_pos(input logic mode32);
        lsb_pos = mode32 ? 6'd31 : 6'd63;
    endfunction

    // Sign-extends the immediate field to the datapath width.
    function automatic logic [63:0] sext_imm(input logic [15:0] imm);
        sext_imm = {{48{imm[15]}}, imm};
    endfunction

    // Packs negative, positive, zero and sticky bits into the condition field.
    function automatic logic [3:0] field_bits(input logic neg, zero, so);
        field_bits = {neg, !neg && !zero, zero, so};
    endfunction

    function automatic logic [31:0] bus_read(input sfa_state_s s, input logic [31:0] a);
        case (a)
            `SFA_OFF_STATUS: bus_read = {30'h0, s.irq_status};
            `SFA_OFF_ENABLE: bus_read = {30'h0, s.irq_enable};
            `SFA_OFF_FLAGS: bus_read = {25'h0, s.cr0, s.so, s.ov, s.ca};
            default: bus_read = 32'h0;
        endcase
    endfunction

    logic [5:0] top;
    logic top_carry;
    logic next_carry;
    logic signed_neg;
    logic part_zero;
    logic wrap;
    logic sets_ca;
    logic takes_flags;
    logic addr_phase;
    logic so_after;
    logic ovf_update;
    logic data_write;
    logic wr_enable;
    logic wr_clear;
    logic wr_ctrl;

    // ------------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------------
    always_comb
    begin
        add.addend_a = ~FIRST_OPERAND_I;
        add.addend_b = SECOND_OPERAND_I;
        add.carry_in = 1'b1;
        case (ISSUE_OP_I)
            SFA_OP_PLAIN,
            SFA_OP_CARRY:
            begin
                add.addend_b = SECOND_OPERAND_I;
                add.carry_in = 1'b1;
            end
            SFA_OP_EXT:
            begin
                add.addend_b = SECOND_OPERAND_I;
                add.carry_in = st_reg.ca;
            end
            SFA_OP_IMM:
            begin
                add.addend_b = sext_imm(SIGNED_IMMEDIATE_I);
                add.carry_in = 1'b1;
            end
            SFA_OP_MINUS1:
            begin
                add.addend_b = `SFA_ALL_ONES;
                add.carry_in = st_reg.ca;
            end
            SFA_OP_ZERO:
            begin
                add.addend_b = 64'h0;
                add.carry_in = st_reg.ca;
            end
            default:
            begin
                add.addend_b = SECOND_OPERAND_I;
                add.carry_in = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Flag evaluation
    // ------------------------------------------------------------------
    always_comb
    begin
        top = lsb_pos(MODE32_I);
        top_carry = add.carries[{1'b0, top} + 7'd1];
        next_carry = add.carries[top];
        wrap = top_carry ^ next_carry;
        signed_neg = add.sum[top];
        part_zero = MODE32_I ? (add.sum[31:0] == 32'h0) : (add.sum == 64'h0);
        sets_ca = (ISSUE_OP_I != SFA_OP_PLAIN);
        takes_flags = (ISSUE_OP_I != SFA_OP_IMM);
        addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];
        so_after = st_reg.so | wrap;
        ovf_update = ISSUE_VALID_I && takes_flags && OVF_ENABLE_I;
        data_write = st_reg.bus_state == SFA_BUS_DATA && st_reg.bus_write;
        wr_enable = data_write && st_reg.bus_addr == `SFA_OFF_ENABLE;
        wr_clear = data_write && st_reg.bus_addr == `SFA_OFF_CLEAR;
        wr_ctrl = data_write && st_reg.bus_addr == `SFA_OFF_CTRL;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.valid = ISSUE_VALID_I;
        st_next.sticky_clr = 1'b0;
        // --------------------------------------------------------------
        // Issue result and flags
        // --------------------------------------------------------------
        if (ISSUE_VALID_I)
        begin
            st_next.result = add.sum;
            if (sets_ca)
            begin
                st_next.ca = top_carry;
            end
            if (ovf_update)
            begin
                st_next.ov = wrap;
                st_next.so = so_after;
            end
            if (takes_flags && RECORD_BIT_I)
            begin
                st_next.cr0 = field_bits(signed_neg, part_zero,
                    OVF_ENABLE_I ? so_after : st_reg.so);
            end
        end
        // --------------------------------------------------------------
        // Bus data phase
        // --------------------------------------------------------------
        // Writes land here; reads were captured in the address phase.
        if (wr_enable)
        begin
            st_next.irq_enable = HWDATA_I[`SFA_IRQ_W-1:0];
        end
        if (wr_clear)
        begin
            st_next.irq_status = st_reg.irq_status & ~HWDATA_I[`SFA_IRQ_W-1:0];
        end
        if (wr_ctrl)
        begin
            st_next.sticky_clr = HWDATA_I[0];
        end
        // An overflow-enabled issue of any form but immediate in the same cycle keeps the sticky flag.
        if (st_next.sticky_clr && !ovf_update)
        begin
            st_next.so = 1'b0;
        end
        // --------------------------------------------------------------
        // Events
        // --------------------------------------------------------------
        // Events set after any clear so a same-cycle event is kept.
        if (ISSUE_VALID_I)
        begin
            st_next.irq_status[`SFA_IRQ_DONE] = 1'b1;
        end
        if (ovf_update && wrap)
        begin
            st_next.irq_status[`SFA_IRQ_WRAP] = 1'b1;
        end
        // --------------------------------------------------------------
        // Bus address phase
        // --------------------------------------------------------------
        if (addr_phase)
        begin
            st_next.bus_state = SFA_BUS_DATA;
            st_next.bus_write = HWRITE_I;
            st_next.bus_addr = HADDR_I;
            st_next.rdata = bus_read(st_reg, HADDR_I);
        end
        else if (HREADY_I)
        begin
            st_next.bus_state = SFA_BUS_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Issue result and flags, all straight from the state register.
    assign RESULT_VALID_O = st_reg.valid;
    assign RESULT_O = st_reg.result;
    assign BORROW_OUT_BIT_O = st_reg.ca;
    assign SIGNED_WRAP_FLAG_O = st_reg.ov;
    assign STICKY_WRAP_O = st_reg.so;
    assign CONDITION_FIELD_ZERO_O = st_reg.cr0;

    // Bus response: zero wait states and always OKAY.
    assign HRDATA_O = st_reg.rdata;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    // Level interrupt from the enabled status bits.
    assign IRQ_O = |(st_reg.irq_status & st_reg.irq_enable);
endmodule // sfa_alu

// File: bench/sfa_alu_checker.sv
// Port assertions for the subtract-family datapath.
module sfa_alu_checker
    import sfa_pkg::*;
(
    // Clock, reset and issue.
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic ISSUE_VALID_I,
    input wire sfa_op_e ISSUE_OP_I,
    input wire logic OVF_ENABLE_I,
    input wire logic RECORD_BIT_I,
    input wire logic [63:0] FIRST_OPERAND_I,
    input wire logic [63:0] SECOND_OPERAND_I,
    // Result and flags.
    input wire logic RESULT_VALID_O,
    input wire logic [63:0] RESULT_O,
    input wire logic BORROW_OUT_BIT_O,
    input wire logic SIGNED_WRAP_FLAG_O,
    input wire logic STICKY_WRAP_O,
    input wire logic [3:0] CONDITION_FIELD_ZERO_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);
    a_result_pulse: assert property (ISSUE_VALID_I |=> RESULT_VALID_O)
        else $error("no result pulse");
    a_no_spurious: assert property (!ISSUE_VALID_I |=> !RESULT_VALID_O)
        else $error("stray result pulse");
    a_plain_sum: assert property (ISSUE_VALID_I && ISSUE_OP_I == SFA_OP_PLAIN |=>
        RESULT_O == ~$past(FIRST_OPERAND_I) + $past(SECOND_OPERAND_I) + 64'h1)
        else $error("plain sum wrong");
    a_plain_carry: assert property (ISSUE_VALID_I && ISSUE_OP_I == SFA_OP_PLAIN |=>
        $stable(BORROW_OUT_BIT_O)) else $error("plain form moved carry");
    a_imm_flags: assert property (ISSUE_VALID_I && ISSUE_OP_I == SFA_OP_IMM |=>
        $stable(SIGNED_WRAP_FLAG_O) && $stable(CONDITION_FIELD_ZERO_O))
        else $error("immediate form moved flags");
    a_no_record: assert property (ISSUE_VALID_I && !RECORD_BIT_I |=>
        $stable(CONDITION_FIELD_ZERO_O)) else $error("field moved");
    a_no_enable: assert property (ISSUE_VALID_I && !OVF_ENABLE_I |=>
        $stable(SIGNED_WRAP_FLAG_O)) else $error("wrap moved");
    a_sticky_or: assert property (ISSUE_VALID_I && OVF_ENABLE_I &&
        ISSUE_OP_I != SFA_OP_IMM |=>
        STICKY_WRAP_O == ($past(STICKY_WRAP_O) | SIGNED_WRAP_FLAG_O))
        else $error("sticky not gathered");
    a_field_sticky: assert property (ISSUE_VALID_I && RECORD_BIT_I &&
        ISSUE_OP_I != SFA_OP_IMM |=> CONDITION_FIELD_ZERO_O[0] == STICKY_WRAP_O)
        else $error("field sticky bit wrong");
endmodule // sfa_alu_checker
bind sfa_alu sfa_alu_checker i_sfa_alu_checker (.CORE_CLK_I, .RESET_I, .ISSUE_VALID_I,
    .ISSUE_OP_I, .OVF_ENABLE_I, .RECORD_BIT_I, .FIRST_OPERAND_I, .SECOND_OPERAND_I,
    .RESULT_VALID_O, .RESULT_O, .BORROW_OUT_BIT_O, .SIGNED_WRAP_FLAG_O, .STICKY_WRAP_O,
    .CONDITION_FIELD_ZERO_O);

// File: bench/sfa_issue_model.sv
// Issue-stage model that hands subtract operations to the datapath.
module sfa_issue_model
    import sfa_pkg::*;
(
    // Clock.
    input wire logic clk_i,
    // Issue lines.
    output logic valid_o,
    output sfa_op_e op_o,
    output logic [2:0] ctl_o,
    output logic [63:0] a_o,
    output logic [63:0] b_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {valid_o, ctl_o, a_o, b_o} = '0;
        op_o = SFA_OP_PLAIN;
    end
    // Back-to-back calls keep valid high.
    task automatic issue(input sfa_op_e o, input logic [2:0] c, input logic [63:0] a, b);
        @(posedge clk_i);
        valid_o <= 1'b1;
        op_o <= o;
        ctl_o <= c;
        a_o <= a;
        b_o <= b;
    endtask
    // Idle operands toggle so stale values are never mistaken for live ones.
    task automatic idle();
        @(posedge clk_i);
        valid_o <= 1'b0;
        a_o <= ~a_o;
        b_o <= ~b_o;
    endtask
endmodule // sfa_issue_model

// File: bench/subtract_family_alu_bench.sv
// Self-checking bench of the subtract-family datapath.
`include "sfa_cfg.svh"
module subtract_family_alu_bench
    import sfa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0, hwr = 1'b0, rdy, v, irq, rv, hresp;
    logic [1:0] htr = 2'h0;
    logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, seed = 32'h3b89;
    logic [63:0] a, b, ra, rb;
    logic [2:0] c;
    wire logic [70:0] got;
    logic [70:0] q[$];
    sfa_op_e op;
    logic m_ca = 1'b0, m_ov = 1'b0, m_so = 1'b0, m_wrap = 1'b0;
    logic [3:0] m_cr = 4'h0;
    int bad_count = 0;
    int tests_run = 0;
    always #2.5 clk = ~clk;
    sfa_issue_model i_sfa_issue_model (.clk_i(clk), .valid_o(v), .op_o(op), .ctl_o(c),
        .a_o(a), .b_o(b));
    sfa_alu i_sfa_alu (.CORE_CLK_I(clk), .RESET_I(rst), .ISSUE_VALID_I(v), .ISSUE_OP_I(op),
        .OVF_ENABLE_I(c[0]), .RECORD_BIT_I(c[1]), .MODE32_I(c[2]), .FIRST_OPERAND_I(a),
        .SECOND_OPERAND_I(b), .SIGNED_IMMEDIATE_I(b[15:0]), .RESULT_VALID_O(rv),
        .RESULT_O(got[70:7]), .BORROW_OUT_BIT_O(got[6]), .SIGNED_WRAP_FLAG_O(got[5]),
        .STICKY_WRAP_O(got[4]), .CONDITION_FIELD_ZERO_O(got[3:0]), .HSEL_I(hsel), .HADDR_I(ha),
        .HTRANS_I(htr), .HWRITE_I(hwr), .HSIZE_I(3'h2), .HWDATA_I(hwd), .HREADY_I(rdy),
        .HRDATA_O(hrd), .HREADYOUT_O(rdy), .HRESP_O(hresp), .IRQ_O(irq));
    task automatic check(input logic [70:0] g, e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] ad, d, e);
        @(posedge clk);
        {hsel, htr, ha, hwr} <= {1'b1, 2'h2, ad, w};
        do @(posedge clk); while (rdy !== 1'b1);
        {htr, hwd} <= {2'h0, d};
        do @(posedge clk); while (rdy !== 1'b1);
        check(71'(hresp), 71'h0);
        if (!w)
            check(71'(hrd), 71'(e));
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Reference model: notes the expected result, then issues the operation.
    task automatic step(input sfa_op_e o, input logic [2:0] k, input logic [63:0] x, y);
        logic [63:0] na, bb, s;
        logic c64, ci, w, ng, zr;
        logic [32:0] t;
        int tp;
        na = ~x;
        bb = o == SFA_OP_IMM ? {{48{y[15]}}, y[15:0]} : o == SFA_OP_MINUS1 ? '1 :
            o == SFA_OP_ZERO ? 64'h0 : y;
        ci = o inside {SFA_OP_EXT, SFA_OP_MINUS1, SFA_OP_ZERO} ? m_ca : 1'b1;
        {c64, s} = {1'b0, na} + {1'b0, bb} + 65'(ci);
        t = {1'b0, na[31:0]} + {1'b0, bb[31:0]} + 33'(ci);
        tp = k[2] ? 31 : 63;
        w = na[tp] == bb[tp] && s[tp] != na[tp] && k[0] && o != SFA_OP_IMM;
        ng = s[tp];
        zr = k[2] ? s[31:0] == 32'h0 : s == 64'h0;
        m_ca = o == SFA_OP_PLAIN ? m_ca : k[2] ? t[32] : c64;
        m_ov = k[0] && o != SFA_OP_IMM ? w : m_ov;
        m_so = m_so | w;
        m_wrap = m_wrap | w;
        m_cr = k[1] && o != SFA_OP_IMM ? {ng, !ng && !zr, zr, m_so} : m_cr;
        q.push_back({s, m_ca, m_ov, m_so, m_cr});
        i_sfa_issue_model.issue(o, k, x, y);
    endtask
    always @(negedge clk)
        if (rv === 1'b1)
        begin
            if (q.size() == 0)
            begin
                bad_count++;
                $display("wrong value at %0t: result with no note", $time);
            end
            else
                check(got, q.pop_front());
        end
    initial
    begin
        #20000;
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(0, `SFA_OFF_FLAGS, 0, 0);
        bus(1, `SFA_OFF_ENABLE, 3, 0);
        bus(0, `SFA_OFF_ENABLE, 0, 3);
        for (int k = 0; k < 96; k++)
        begin
            seed = lfsr(lfsr(seed));
            ra = k < 48 ? {seed, lfsr(seed)} : 64'h7fff_ffff_7fff_ffff;
            rb = k < 48 ? {lfsr(seed), seed} : k[0] ? ra : 64'h8000_0000_8000_0000;
            step(sfa_op_e'(k % 6), 3'(k / 6), ra, rb);
        end
        i_sfa_issue_model.idle();
        repeat (2) @(negedge clk);
        check(71'(irq), 71'h1);
        bus(0, `SFA_OFF_STATUS, 0, {30'h0, m_wrap, 1'b1});
        bus(0, `SFA_OFF_FLAGS, 0, {25'h0, m_cr, m_so, m_ov, m_ca});
        bus(1, `SFA_OFF_CLEAR, 3, 0);
        bus(0, `SFA_OFF_STATUS, 0, 0);
        bus(1, `SFA_OFF_CTRL, 1, 0);
        bus(0, `SFA_OFF_FLAGS, 0, {25'h0, m_cr, 1'b0, m_ov, m_ca});
        bus(0, 32'h20, 0, 0);
        m_so = 1'b0;
        bus(1, `SFA_OFF_ENABLE, 0, 0);
        step(SFA_OP_CARRY, 3'h0, 64'h0, 64'h0);
        i_sfa_issue_model.idle();
        repeat (2) @(negedge clk);
        check(71'(irq), 71'h0);
        if (q.size() != 0)
        begin
            bad_count++;
            $display("wrong value at %0t: results missing", $time);
        end
        report_and_stop();
    end
endmodule // subtract_family_alu_bench
